// [hdl/limit_timer_reset_control.sv]
// limit timer with selectable peripheral edge reset, AXI4-Lite slave
`timescale 1ns/1ps
module limit_timer_reset_control (
  input  wire logic                           ref_clk,
  input  wire logic                           nrst,
  input  wire limit_timer_pkg::reset_sources_t resetSources,
  output logic                                limitMatchPulse,
  input  wire logic [3:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [3:0]                     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready
);
  localparam int PW = limit_timer_pkg::PRESCALE_W;

  limit_timer_pkg::control_0_t control0_ff;
  limit_timer_pkg::control_1_t control1_ff;
  logic [7:0]    count_ff;
  logic [7:0]    period_ff;
  logic [PW-1:0] prescaleCnt_ff;
  logic [5:0]    sync1_ff;
  logic [5:0]    sync2_ff;
  logic          srcPrev_ff;
  logic          pendingClear_ff;
  logic          match_ff;
  logic [3:0]    awAddr_ff;
  logic          awHeld_ff;
  logic [7:0]    wData_ff;
  logic          wLane0_ff;
  logic          wHeld_ff;
  logic          bvalid_ff;
  logic [1:0]    bresp_ff;
  logic          rvalid_ff;
  logic [31:0]   rdata_ff;
  logic [1:0]    rresp_ff;

  // decode of a byte address to one of the four registers
  function automatic logic is_mapped(input logic [3:0] a);
    is_mapped = (a == limit_timer_pkg::OFF_CONTROL_0) ||
                (a == limit_timer_pkg::OFF_CONTROL_1) ||
                (a == limit_timer_pkg::OFF_COUNT) ||
                (a == limit_timer_pkg::OFF_PERIOD);
  endfunction

  // divide ratio minus one for the prescale code: 1, 4, 16, 64
  function automatic logic [PW-1:0] prescale_top(input logic [1:0] code);
    prescale_top = PW'((1 << (2 * code)) - 1);
  endfunction

  // write path: both halves held, then performed in one cycle
  wire doWrite  = awHeld_ff && wHeld_ff && !bvalid_ff;
  wire wrMapped = is_mapped(awAddr_ff);
  wire wrEn0 = doWrite && wLane0_ff &&
               (awAddr_ff == limit_timer_pkg::OFF_CONTROL_0);
  wire wrEn1 = doWrite && wLane0_ff &&
               (awAddr_ff == limit_timer_pkg::OFF_CONTROL_1);
  wire wrEnCount = doWrite && wLane0_ff &&
                   (awAddr_ff == limit_timer_pkg::OFF_COUNT);
  wire wrEnPeriod = doWrite && wLane0_ff &&
                    (awAddr_ff == limit_timer_pkg::OFF_PERIOD);
  // a half is taken only on a real handshake, never on the reset edge
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake  = s_axi_wvalid && s_axi_wready;

  // read path: one read in flight, address taken only when idle
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire [7:0] rdByte =
    (s_axi_araddr == limit_timer_pkg::OFF_CONTROL_0) ?
      (control0_ff & limit_timer_pkg::MASK_CONTROL_0) :
    (s_axi_araddr == limit_timer_pkg::OFF_CONTROL_1) ?
      (control1_ff & limit_timer_pkg::MASK_CONTROL_1) :
    (s_axi_araddr == limit_timer_pkg::OFF_COUNT) ? count_ff :
    (s_axi_araddr == limit_timer_pkg::OFF_PERIOD) ? period_ff : 8'h00;

  // timer tick from the prescaler while the timer is on
  wire tick = control0_ff.timerOn &&
              (prescaleCnt_ff == prescale_top(control0_ff.prescale));

  // source multiplexer on the synchronised inputs
  wire [2:0] sel = control1_ff.resetSourceSelect;
  wire srcLevel =
    (sel == limit_timer_pkg::SRC_CAPTURE) ? sync2_ff[5] :
    (sel == limit_timer_pkg::SRC_COMP_A)  ? sync2_ff[4] :
    (sel == limit_timer_pkg::SRC_COMP_B)  ? sync2_ff[3] :
    (sel == limit_timer_pkg::SRC_GEN_A)   ? sync2_ff[2] :
    (sel == limit_timer_pkg::SRC_GEN_C)   ? sync2_ff[1] :
    (sel == limit_timer_pkg::SRC_GEN_B)   ? sync2_ff[0] :
    1'b0;
  wire riseEv = srcLevel && !srcPrev_ff && control1_ff.risingResetEnable;
  wire fallEv = !srcLevel && srcPrev_ff && control1_ff.fallingResetEnable;
  wire edgeEv = riseEv || fallEv;
  wire clearNow = tick && (pendingClear_ff || edgeEv);
  wire matchNow = tick && !clearNow && (count_ff == period_ff);

  // next-state values of the counter
  wire [7:0] nxt_count =
    wrEnCount ? wData_ff :
    clearNow  ? 8'h00 :
    matchNow  ? 8'h00 :
    tick      ? 8'(count_ff + 8'h01) : count_ff;

  // sources come from other blocks on other timing; two flops first
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_ff   <= 6'h00;
      sync2_ff   <= 6'h00;
      srcPrev_ff <= 1'b0;
    end else begin
      sync1_ff   <= resetSources;
      sync2_ff   <= sync1_ff;
      srcPrev_ff <= srcLevel;
    end
  end

  // an edge between ticks waits here; a tick clears it, an edge on that tick acts at once
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pendingClear_ff <= 1'b0;
    end else if (edgeEv && !tick) begin
      pendingClear_ff <= 1'b1;
    end else if (tick) begin
      pendingClear_ff <= 1'b0;
    end
  end

  // prescaler restarts whenever the timer is off
  always_ff @(posedge ref_clk) begin
    if (!nrst || !control0_ff.timerOn || tick) begin
      prescaleCnt_ff <= '0;
    end else begin
      prescaleCnt_ff <= PW'(prescaleCnt_ff + 1'b1);
    end
  end

  // counter and match pulse; a peripheral clear masks the match
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count_ff <= limit_timer_pkg::RST_COUNT;
      match_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      match_ff <= matchNow;
    end
  end

  // software registers; unimplemented bits are masked off
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      control0_ff <= limit_timer_pkg::RST_CONTROL_0;
      control1_ff <= limit_timer_pkg::RST_CONTROL_1;
      period_ff   <= limit_timer_pkg::RST_PERIOD;
    end else begin
      if (wrEn0) begin
        control0_ff <= wData_ff & limit_timer_pkg::MASK_CONTROL_0;
      end
      if (wrEn1) begin
        control1_ff <= wData_ff & limit_timer_pkg::MASK_CONTROL_1;
      end
      if (wrEnPeriod) begin
        period_ff <= wData_ff;
      end
    end
  end

  // write address and data captured independently, in any order
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff  <= 8'h00;
      wLane0_ff <= 1'b0;
    end else begin
      if (awTake) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (wTake) begin
        wHeld_ff  <= 1'b1;
        wData_ff  <= s_axi_wdata[7:0];
        wLane0_ff <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer with a slave error
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= limit_timer_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wrMapped ? limit_timer_pkg::RESP_OKAY :
                              limit_timer_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read data; narrow registers sit in the low byte, upper bits zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= limit_timer_pkg::RESP_OKAY;
    end else if (arTake) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h000000, rdByte};
      rresp_ff  <= is_mapped(s_axi_araddr) ? limit_timer_pkg::RESP_OKAY :
                                             limit_timer_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ready flags registered so every output comes from a flop
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      arready_ff <= 1'b0;
    end else begin
      awready_ff <= !(awHeld_ff || awTake) || doWrite;
      wready_ff  <= !(wHeld_ff || wTake) || doWrite;
      arready_ff <= !(rvalid_ff || arTake) ||
                    (rvalid_ff && s_axi_rready);
    end
  end

  assign limitMatchPulse = match_ff;
  assign s_axi_awready   = awready_ff;
  assign s_axi_wready    = wready_ff;
  assign s_axi_arready   = arready_ff;
  assign s_axi_bvalid    = bvalid_ff;
  assign s_axi_bresp     = bresp_ff;
  assign s_axi_rvalid    = rvalid_ff;
  assign s_axi_rdata     = rdata_ff;
  assign s_axi_rresp     = rresp_ff;
endmodule

// [hdl/limit_timer_pkg.sv]
// constants and carrier types for the limit timer reset control block
package limit_timer_pkg;
  // register byte addresses on the bus
  localparam logic [3:0] OFF_CONTROL_0 = 4'h0;
  localparam logic [3:0] OFF_CONTROL_1 = 4'h4;
  localparam logic [3:0] OFF_COUNT     = 4'h8;
  localparam logic [3:0] OFF_PERIOD    = 4'hC;

  // implemented bits of each control register
  localparam logic [7:0] MASK_CONTROL_0 = 8'h7F;
  localparam logic [7:0] MASK_CONTROL_1 = 8'h1F;

  // reset values
  localparam logic [7:0] RST_CONTROL_0 = 8'h00;
  localparam logic [7:0] RST_CONTROL_1 = 8'h00;
  localparam logic [7:0] RST_COUNT     = 8'h00;
  localparam logic [7:0] RST_PERIOD    = 8'hFF;

  // reset source select codes
  localparam logic [2:0] SRC_CAPTURE = 3'h0;
  localparam logic [2:0] SRC_COMP_A  = 3'h1;
  localparam logic [2:0] SRC_COMP_B  = 3'h2;
  localparam logic [2:0] SRC_GEN_A   = 3'h3;
  localparam logic [2:0] SRC_GEN_C   = 3'h4;
  localparam logic [2:0] SRC_GEN_B   = 3'h5;

  // prescaler: each code step multiplies the divide ratio by four
  localparam int PRESCALE_W = 6;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register 0 layout
  typedef struct packed {
    logic       unused7;
    logic [3:0] postscale;
    logic       timerOn;
    logic [1:0] prescale;
  } control_0_t;

  // control register 1 layout
  typedef struct packed {
    logic [2:0] unused;
    logic [2:0] resetSourceSelect;
    logic       fallingResetEnable;
    logic       risingResetEnable;
  } control_1_t;

  // peripheral signals that can reset the counter
  typedef struct packed {
    logic captureCompareOutput;
    logic comparatorAOutput;
    logic comparatorBOutput;
    logic outputGeneratorLineA;
    logic outputGeneratorLineC;
    logic outputGeneratorLineB;
  } reset_sources_t;
endpackage

// [tb/limit_timer_source_model.sv]
// peripheral reset source lines: loaded levels, optional toggling
`timescale 1ns/1ps
module limit_timer_source_model (
  input  wire logic                            ref_clk,
  input  wire logic                            loadLines,
  input  wire limit_timer_pkg::reset_sources_t lineVal,
  input  wire limit_timer_pkg::reset_sources_t toggleMask,
  output limit_timer_pkg::reset_sources_t      resetSources = '0
);
  logic [2:0] phase_ff = 3'h0;
  // lines move on the clock only; masked lines flip every 8 clocks
  always @(posedge ref_clk) begin
    phase_ff <= phase_ff + 3'h1;
    if (loadLines) resetSources <= lineVal;
    else if (phase_ff == 3'h7) resetSources <= resetSources ^ toggleMask;
  end
endmodule

// [tb/limit_timer_reset_control_chk.sv]
// bus and reset checks on the limit timer ports
`timescale 1ns/1ps
module limit_timer_reset_control_chk (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        limitMatchPulse,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [3:0] rdAddr_ff;
  wire unmapped = rdAddr_ff[1:0] != 2'h0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // address of the read in flight, to judge its answer
  always_ff @(posedge ref_clk)
    if (s_axi_arvalid && s_axi_arready) rdAddr_ff <= s_axi_araddr;
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during read answer");
  chk_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  chk_ctl1_unused: assert property (
    s_axi_rvalid && rdAddr_ff == 4'h4 |-> s_axi_rdata[7:5] == 3'h0)
    else $error("control1 unused bits set");
  chk_unmapped_err: assert property (s_axi_rvalid && unmapped |->
    s_axi_rresp == limit_timer_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answer");
  chk_mapped_okay: assert property (s_axi_rvalid && !unmapped |->
    s_axi_rresp == limit_timer_pkg::RESP_OKAY) else $error("mapped resp");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !nrst |=> !s_axi_rvalid && !s_axi_bvalid && !limitMatchPulse)
    else $error("outputs active in reset");
  cover property (s_axi_rvalid && rdAddr_ff == 4'h4);
  cover property (s_axi_rvalid && unmapped);
  cover property (limitMatchPulse);
endmodule
bind limit_timer_reset_control limit_timer_reset_control_chk chk (.*);

// [tb/tb.sv]
// self-checking bench for the limit timer reset control
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0, nrst = 1'b0, loadLines = 1'b0, limitMatchPulse;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rise, ex;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  limit_timer_pkg::reset_sources_t resetSources, lineVal = '0;
  limit_timer_pkg::reset_sources_t toggleMask = '0;
  logic [16:0] seed = 17'h171C4;
  int err_count = 0, samples_checked = 0, pulses = 0, p0;
  limit_timer_reset_control dut (.*);
  limit_timer_source_model src (.*);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (limitMatchPulse === 1'b1) pulses++;
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  task automatic check(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // both halves offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic s);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= {3'h0, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge ref_clk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // trailing edge keeps back-to-back reads from reassigning rready at once
  task automatic rd(input logic [3:0] a);
    logic ar;
    ar = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) ar = 1'b0;
      s_axi_arvalid <= ar;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    rd(a);
    check(n, {24'h0, e}, d);
    check("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic lines(input logic [5:0] v);
    lineVal <= v;
    loadLines <= 1'b1;
    @(posedge ref_clk);
    loadLines <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rc("control0", 4'h0, limit_timer_pkg::RST_CONTROL_0, 2'h0);
    rc("control1", 4'h4, 8'h00, 2'h0);
    rc("count", 4'h8, limit_timer_pkg::RST_COUNT, 2'h0);
    rc("period", 4'hC, limit_timer_pkg::RST_PERIOD, 2'h0);
    seed = lfsr(seed);
    wr(4'h4, seed[7:0], 1'b1);
    rc("control1", 4'h4, seed[7:0] & 8'h1F, 2'h0);
    wr(4'h0, seed[15:8] & 8'hFB, 1'b1);
    rc("control0", 4'h0, seed[15:8] & 8'h7B, 2'h0);
    wr(4'hC, seed[12:5], 1'b1);
    rc("period", 4'hC, seed[12:5], 2'h0);
    wr(4'h8, seed[9:2], 1'b1);
    wr(4'h8, ~seed[9:2], 1'b0);
    rc("count", 4'h8, seed[9:2], 2'h0);
    wr(4'h6, 8'h55, 1'b1);
    check("bresp", limit_timer_pkg::RESP_SLVERR, r);
    rc("unmapped", 4'h6, 8'h00, limit_timer_pkg::RESP_SLVERR);
    wr(4'hC, 8'hFF, 1'b1);
    wr(4'h0, 8'h04, 1'b1);
    // every select code, enables cycling, polarity drawn at random
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      rise = seed[3];
      lines({6{~rise}});
      wr(4'h4, {3'h0, 3'(c), 2'(c + 1)}, 1'b1);
      repeat (6) @(posedge ref_clk);
      wr(4'h8, 8'h80, 1'b1);
      lines(c < 6 ? {6{~rise}} ^ (6'h20 >> c) : {6{rise}});
      repeat (4) @(posedge ref_clk);
      rd(4'h8);
      ex = c < 6 && (rise ? 2'(c + 1) & 2'h1 : 2'(c + 1) >> 1);
      check("cleared", 32'(ex), 32'(d[7:0] < 8'h40));
    end
    // frequent clears must hold off every match
    wr(4'hC, 8'h20, 1'b1);
    wr(4'h4, 8'h03, 1'b1);
    toggleMask <= 6'h20;
    repeat (20) @(posedge ref_clk);
    p0 = pulses;
    repeat (200) @(posedge ref_clk);
    check("no match", p0, pulses);
    toggleMask <= 6'h00;
    repeat (80) @(posedge ref_clk);
    check("match", 1, 32'(pulses > p0));
    // slowest prescale: one count every 64 clocks, edge resets off
    wr(4'h4, 8'h00, 1'b1);
    wr(4'h0, 8'h07, 1'b1);
    wr(4'h8, 8'h00, 1'b1);
    repeat (640) @(posedge ref_clk);
    rd(4'h8);
    check("slow count", 1, 32'(d[7:0] >= 8'h09 && d[7:0] <= 8'h0B));
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rc("control1", 4'h4, 8'h00, 2'h0);
    results();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    results();
  end
endmodule
